// *** shared/hbd_pkg.sv ***
package hbd_pkg;
   // Register address field, bits 6:2 of the address byte
   localparam logic [4:0] ADDR_GLOBAL = 5'h06;
   localparam logic [4:0] ADDR_OVERCURRENT = 5'h16;
   localparam logic [4:0] ADDR_OPEN_LOAD = 5'h01;
   // Address byte field positions
   localparam int ACCESS_KIND_POS = 7;
   localparam int ADDR_MSB = 6;
   localparam int ADDR_LSB = 2;
   localparam int CHAIN_POS = 1;
   // Global status bit positions
   localparam int GL_SPI_ERR = 7;
   localparam int GL_LOAD_FAULT = 6;
   localparam int GL_SUPPLY_LOW = 5;
   localparam int GL_SUPPLY_HIGH = 4;
   localparam int GL_POWER_UP = 3;
   localparam int GL_THERM_SD = 2;
   localparam int GL_THERM_PW = 1;
   localparam int GL_RSVD = 0;
   // Switch count: three bridges, low side at even bit, high side at odd
   localparam int SWITCHES = 6;
   // Values after power-on reset
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [SWITCHES-1:0] SWITCH_RESET = 6'h00;
   localparam logic [1:0] RSVD_ZERO = 2'h0;
   // Access kind: read only, or read and clear
   localparam logic ACCESS_READ = 1'b0;
   localparam logic ACCESS_CLEAR = 1'b1;

   // One decoded 16-bit serial command
   typedef struct packed {
      logic [7:0] addr_byte;
      logic [7:0] data_byte;
   } hbd_cmd_t;

   // Raw fault conditions from the analog detectors
   typedef struct packed {
      logic supply_low;
      logic supply_high;
      logic therm_sd;
      logic therm_pw;
      logic [SWITCHES-1:0] current_trip;
      logic [SWITCHES-1:0] open_load;
   } hbd_fault_t;
endpackage

// *** src/hbd_diag_bank.sv ***
`timescale 1ns/1ps
module hbd_diag_bank (
   input wire logic mclk,
   input wire logic reset_n,
   // Command from the serial framer, same clock
   input wire logic cmd_valid,
   input wire hbd_pkg::hbd_cmd_t cmd,
   // Malformed frame pulse from the framer, same clock
   input wire logic frame_error,
   // Switch enables from the control registers, same clock
   input wire logic [hbd_pkg::SWITCHES-1:0] ctrl_enable,
   // Raw analog fault levels, asynchronous
   input wire hbd_pkg::hbd_fault_t fault_raw,
   // Data byte answered for the command
   output logic [7:0] resp_data_q,
   output logic resp_valid_q,
   // Gate drive enables after protection
   output logic [hbd_pkg::SWITCHES-1:0] switch_on_q
);

   // Fault synchroniser stages
   hbd_pkg::hbd_fault_t fault_meta_q;
   hbd_pkg::hbd_fault_t fault_q;

   // Sticky flags
   logic spi_err_q, spi_err_d;
   logic uv_q, uv_d;
   logic ov_q, ov_d;
   logic power_up_q, power_up_d;
   logic tsd_q, tsd_d;
   logic tpw_q, tpw_d;
   logic [hbd_pkg::SWITCHES-1:0] oc_q, oc_d;
   logic [hbd_pkg::SWITCHES-1:0] ol_q, ol_d;

   // Command decode
   wire [4:0] addr_field = cmd.addr_byte[hbd_pkg::ADDR_MSB:hbd_pkg::ADDR_LSB];
   wire is_clear = cmd.addr_byte[hbd_pkg::ACCESS_KIND_POS] == hbd_pkg::ACCESS_CLEAR;
   wire sel_global = addr_field == hbd_pkg::ADDR_GLOBAL;
   wire sel_oc = addr_field == hbd_pkg::ADDR_OVERCURRENT;
   wire sel_ol = addr_field == hbd_pkg::ADDR_OPEN_LOAD;
   // Clear strobes, one per register
   wire clr_global = cmd_valid && is_clear && sel_global;
   wire clr_oc = cmd_valid && is_clear && sel_oc;
   wire clr_ol = cmd_valid && is_clear && sel_ol;

   // Summary of all switch flags, no storage of its own
   wire load_fault = (|oc_q) | (|ol_q);
   // Any latched supply fault or thermal shutdown kills every output
   wire global_kill = uv_q | ov_q | tsd_q;

   // Register images
   wire [7:0] global_img = {spi_err_q, load_fault, uv_q, ov_q,
                            power_up_q, tsd_q, tpw_q, 1'b0};
   wire [7:0] oc_img = {hbd_pkg::RSVD_ZERO, oc_q};
   wire [7:0] ol_img = {hbd_pkg::RSVD_ZERO, ol_q};
   // Read mux, unmapped addresses answer zero
   wire [7:0] read_img = sel_global ? global_img :
                         sel_oc ? oc_img :
                         sel_ol ? ol_img : hbd_pkg::STATUS_RESET;

   // Sticky flag update, set wins over clear
   function automatic logic sticky(input logic q, input logic clr, input logic set);
      sticky = (q & ~clr) | set;
   endfunction

   // Cross-current guard: both switches of a bridge on turns the bridge off
   function automatic logic [hbd_pkg::SWITCHES-1:0] no_cross(
      input logic [hbd_pkg::SWITCHES-1:0] en);
      logic [hbd_pkg::SWITCHES-1:0] r;
      r = en;
      for (int b = 0; b < hbd_pkg::SWITCHES; b += 2) begin
         if (en[b] && en[b+1]) begin
            r[b] = 1'b0;
            r[b+1] = 1'b0;
         end
      end
      no_cross = r;
   endfunction

   // Next flag values; flags only drop on a host clear
   always_comb begin
      spi_err_d = sticky(spi_err_q, clr_global, frame_error);
      uv_d = sticky(uv_q, clr_global, fault_q.supply_low);
      ov_d = sticky(ov_q, clr_global, fault_q.supply_high);
      tsd_d = sticky(tsd_q, clr_global, fault_q.therm_sd);
      tpw_d = sticky(tpw_q, clr_global, fault_q.therm_pw);
      // Clear acknowledges power-up, flag then shows no reset seen
      power_up_d = power_up_q | clr_global;
      for (int i = 0; i < hbd_pkg::SWITCHES; i++) begin
         oc_d[i] = sticky(oc_q[i], clr_oc, fault_q.current_trip[i]);
         ol_d[i] = sticky(ol_q[i], clr_ol, fault_q.open_load[i]);
      end
   end

   // Two-flop synchroniser for analog faults
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fault_meta_q <= '0;
         fault_q <= '0;
      end else begin
         fault_meta_q <= fault_raw;
         fault_q <= fault_meta_q;
      end
   end

   // Global flags
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         spi_err_q <= 1'b0;
         uv_q <= 1'b0;
         ov_q <= 1'b0;
         power_up_q <= 1'b0;
         tsd_q <= 1'b0;
         tpw_q <= 1'b0;
      end else begin
         spi_err_q <= spi_err_d;
         uv_q <= uv_d;
         ov_q <= ov_d;
         power_up_q <= power_up_d;
         tsd_q <= tsd_d;
         tpw_q <= tpw_d;
      end
   end

   // Per-switch flags
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oc_q <= hbd_pkg::SWITCH_RESET;
         ol_q <= hbd_pkg::SWITCH_RESET;
      end else begin
         oc_q <= oc_d;
         ol_q <= ol_d;
      end
   end

   // Answer byte: old contents, taken before any clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         resp_data_q <= hbd_pkg::STATUS_RESET;
         resp_valid_q <= 1'b0;
      end else begin
         resp_valid_q <= cmd_valid;
         if (cmd_valid) begin
            resp_data_q <= read_img;
         end
      end
   end

   // Output gating; the prewarning flag plays no part
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         switch_on_q <= hbd_pkg::SWITCH_RESET;
      end else if (global_kill) begin
         switch_on_q <= hbd_pkg::SWITCH_RESET;
      end else begin
         switch_on_q <= no_cross(ctrl_enable) & ~oc_q & ~oc_d;
      end
   end

   // Assertion sequences
   sequence read_global_s;
      cmd_valid && sel_global;
   endsequence

   sequence clear_oc_quiet_s;
      clr_oc && fault_q.current_trip == '0;
   endsequence

   // Frame error shows in the sticky bit and stays until cleared
   property spi_err_p;
      @(posedge mclk) disable iff (!reset_n)
      frame_error ##1 !clr_global [*2] |-> spi_err_q;
   endproperty
   protocol_fault_a: assert property (spi_err_p) else $error("protocol fault not held");

   // Answer to a global read carries the summary and a zero reserved bit
   property global_answer_p;
      @(posedge mclk) disable iff (!reset_n)
      read_global_s |=> resp_data_q[hbd_pkg::GL_LOAD_FAULT] == $past(load_fault)
                     && resp_data_q[hbd_pkg::GL_RSVD] == 1'b0;
   endproperty
   global_answer_a: assert property (global_answer_p) else $error("global answer wrong");

   // Overcurrent answer has zero top bits and flag image
   property oc_answer_p;
      @(posedge mclk) disable iff (!reset_n)
      cmd_valid && sel_oc |=> resp_data_q == {2'h0, $past(oc_q)};
   endproperty
   oc_answer_a: assert property (oc_answer_p) else $error("overcurrent answer wrong");

   // Summary falls once both flag sets are cleared with no fault present
   property summary_drop_p;
      @(posedge mclk) disable iff (!reset_n)
      clear_oc_quiet_s ##0 (ol_q == '0 && fault_q.open_load == '0) |=> !load_fault;
   endproperty
   summary_drop_a: assert property (summary_drop_p) else $error("summary did not drop");

   // Tripped switch is off the cycle after its flag is set
   property trip_off_p;
      @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> (switch_on_q & $past(oc_q)) == '0;
   endproperty
   trip_off_a: assert property (trip_off_p) else $error("tripped switch on");

   // Supply and thermal shutdown faults switch everything off
   property kill_all_p;
      @(posedge mclk) disable iff (!reset_n)
      (uv_q || ov_q || tsd_q) |=> switch_on_q == '0;
   endproperty
   supply_kill_a: assert property (kill_all_p) else $error("outputs on under fault");

   // Prewarning alone leaves outputs following the enables
   property prewarn_on_p;
      @(posedge mclk) disable iff (!reset_n)
      tpw_q && !global_kill && oc_d == '0 && oc_q == '0
      |=> switch_on_q == no_cross($past(ctrl_enable));
   endproperty
   prewarn_keep_a: assert property (prewarn_on_p) else $error("prewarning cut outputs");

   // Latched supply-low flag survives without a clear
   property hold_p;
      @(posedge mclk) disable iff (!reset_n)
      uv_q && !clr_global |=> uv_q;
   endproperty
   flag_hold_a: assert property (hold_p) else $error("flag dropped alone");

   // Persisting open load is set again right after a clear
   property reset_again_p;
      @(posedge mclk) disable iff (!reset_n)
      clr_ol && fault_q.open_load[0] |=> ol_q[0];
   endproperty
   open_load_set_a: assert property (reset_again_p) else $error("open load lost");

   // A read without clear drops no overcurrent flag; new trips still set theirs
   property clear_scope_p;
      @(posedge mclk) disable iff (!reset_n)
      cmd_valid && !is_clear |=> oc_q == ($past(oc_q) | $past(fault_q.current_trip));
   endproperty
   read_only_a: assert property (clear_scope_p) else $error("read changed flags");

   // Power-up flag reads zero on the first edge after reset
   property power_up_p;
      @(posedge mclk) !$past(reset_n) && reset_n |-> !power_up_q;
   endproperty
   power_up_a: assert property (power_up_p) else $error("power-up flag set");

   // Open-load answer has zero top bits and flag image
   property ol_answer_p;
      @(posedge mclk) disable iff (!reset_n)
      cmd_valid && sel_ol |=> resp_data_q == {hbd_pkg::RSVD_ZERO, $past(ol_q)};
   endproperty
   ol_answer_a: assert property (ol_answer_p) else $error("open-load answer wrong");

   // Every command gets exactly one answer strobe one cycle later
   property answer_strobe_p;
      @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> resp_valid_q == $past(cmd_valid);
   endproperty
   answer_strobe_a: assert property (answer_strobe_p) else $error("answer strobe wrong");

   // Clear of the global register acknowledges power-up
   property power_up_ack_p;
      @(posedge mclk) disable iff (!reset_n)
      clr_global |=> power_up_q;
   endproperty
   power_up_ack_a: assert property (power_up_ack_p) else $error("power-up flag not set");

   // Protocol fault drops on a clear with no new frame error
   property protocol_clear_p;
      @(posedge mclk) disable iff (!reset_n)
      clr_global && !frame_error |=> !spi_err_q;
   endproperty
   protocol_clear_a: assert property (protocol_clear_p) else $error("protocol fault not cleared");

   // Any detected open load is latched on the next edge
   property open_load_latch_p;
      @(posedge mclk) disable iff (!reset_n)
      fault_q.open_load != '0 |=> (ol_q & $past(fault_q.open_load)) == $past(fault_q.open_load);
   endproperty
   open_load_latch_a: assert property (open_load_latch_p) else $error("open load not latched");

   // Unmapped address answers zero
   property unmapped_zero_p;
      @(posedge mclk) disable iff (!reset_n)
      cmd_valid && !sel_global && !sel_oc && !sel_ol |=> resp_data_q == hbd_pkg::STATUS_RESET;
   endproperty
   unmapped_zero_a: assert property (unmapped_zero_p) else $error("unmapped answer not zero");

endmodule

// *** dv/hbd_host_model.sv ***
`timescale 1ns/1ps
// Host side of the command path: one command at a time, answer read one edge after it is taken
module hbd_host_model (
   input wire logic mclk,
   output logic cmd_valid,
   output hbd_pkg::hbd_cmd_t cmd,
   input wire logic [7:0] resp_data_q,
   input wire logic resp_valid_q
);
   // Idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // One command; address bit 7 low reads, high clears
   task automatic xfer(input logic [7:0] addr, output logic [7:0] data, output logic seen);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= '{addr_byte: addr, data_byte: 8'h00};
      // Command taken at this edge
      @(posedge mclk);
      // Released bus changes pattern so no stale value looks valid
      cmd_valid <= 1'b0;
      cmd <= ~cmd;
      // Answer launched at the taking edge stands until this edge
      @(posedge mclk);
      seen = resp_valid_q;
      data = resp_data_q;
   endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for the diagnostic status bank
module tb_top;
   // One table row: fault levels, frame error, command, expected answer
   typedef struct packed {
      logic [15:0] fault;
      logic ferr;
      logic [7:0] addr;
      logic [7:0] exp;
   } hbd_row_t;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid;
   hbd_pkg::hbd_cmd_t cmd;
   logic frame_error = 1'b0;
   logic [5:0] ctrl_enable = 6'h00;
   logic [15:0] fault_raw = 16'h0000;
   logic [7:0] resp_data_q;
   logic resp_valid_q;
   logic [5:0] switch_on_q;
   int miscompares = 0;
   int compares = 0;
   hbd_row_t rows [13];

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   hbd_diag_bank i_hbd_diag_bank (
      .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .frame_error(frame_error), .ctrl_enable(ctrl_enable),
      .fault_raw(hbd_pkg::hbd_fault_t'(fault_raw)), .resp_data_q(resp_data_q),
      .resp_valid_q(resp_valid_q), .switch_on_q(switch_on_q)
   );

   hbd_host_model i_hbd_host_model (
      .mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd),
      .resp_data_q(resp_data_q), .resp_valid_q(resp_valid_q)
   );

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Command with answer and answer strobe checked
   task automatic cmd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_hbd_host_model.xfer(addr, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask

   // Gate enables as left by the previous edge
   task automatic chk_sw(input logic [7:0] exp);
      check({2'h0, switch_on_q}, exp);
   endtask

   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      final_report();
   end

   // Main sequence
   initial begin
      rows = '{
         '{16'h8000, 1'b0, 8'h98, 8'h20},
         '{16'h4000, 1'b0, 8'h98, 8'h18},
         '{16'h2000, 1'b0, 8'h98, 8'h0c},
         '{16'h1000, 1'b0, 8'h98, 8'h0a},
         '{16'h0000, 1'b1, 8'h98, 8'h88},
         '{16'h0800, 1'b0, 8'h58, 8'h20},
         '{16'h0000, 1'b0, 8'h18, 8'h48},
         '{16'h0001, 1'b0, 8'h04, 8'h01},
         '{16'h0000, 1'b0, 8'hd8, 8'h20},
         '{16'h0000, 1'b0, 8'h18, 8'h48},
         '{16'h0000, 1'b0, 8'h84, 8'h01},
         '{16'h0000, 1'b0, 8'h18, 8'h08},
         '{16'h0000, 1'b0, 8'h7c, 8'h00}
      };
      wait_cyc(20);
      reset_n <= 1'b1;
      // Values after power-on reset
      cmd_chk(8'h18, 8'h00);
      cmd_chk(8'h58, 8'h00);
      cmd_chk(8'h04, 8'h00);
      // Table: raise a fault, let it go, then read or clear
      foreach (rows[i]) begin
         fault_raw <= rows[i].fault;
         frame_error <= rows[i].ferr;
         @(posedge mclk);
         frame_error <= 1'b0;
         wait_cyc(5);
         fault_raw <= 16'h0000;
         wait_cyc(4);
         cmd_chk(rows[i].addr, rows[i].exp);
      end
      // Overcurrent holds switch 0 off until cleared
      ctrl_enable <= 6'h01;
      wait_cyc(3);
      chk_sw(8'h01);
      fault_raw <= 16'h0040;
      wait_cyc(5);
      chk_sw(8'h00);
      cmd_chk(8'hd8, 8'h01);
      wait_cyc(5);
      cmd_chk(8'h58, 8'h01);
      fault_raw <= 16'h0000;
      wait_cyc(5);
      chk_sw(8'h00);
      cmd_chk(8'hd8, 8'h01);
      wait_cyc(3);
      chk_sw(8'h01);
      // Supply low drops switch 0, prewarning keeps it on
      fault_raw <= 16'h8000;
      wait_cyc(5);
      chk_sw(8'h00);
      fault_raw <= 16'h1000;
      wait_cyc(4);
      cmd_chk(8'h98, 8'h2a);
      wait_cyc(3);
      chk_sw(8'h01);
      // Bridge 2 asked on at both sides stays off, bridge 1 low side runs
      ctrl_enable <= 6'h0d;
      wait_cyc(3);
      chk_sw(8'h01);
      // Reset in mid-run brings back the power-up value
      fault_raw <= 16'h0000;
      reset_n <= 1'b0;
      wait_cyc(2);
      chk_sw(8'h00);
      reset_n <= 1'b1;
      cmd_chk(8'h18, 8'h00);
      final_report();
   end
endmodule
